/* count_pin_model.sv */
// Far side of the timer 0 count pin: pull-up, pulse source, shared wire
`timescale 1ns/1ns

module count_pin_model (
    input  wire logic pin_o_i,
    input  wire logic pin_oe_n_i,
    input  wire logic pull_low_i,
    output logic      level_o
);
    // -----------------------------------------------------------------
    // Wire resolution
    // -----------------------------------------------------------------
    // Released wire rests at the pull-up level, never the last value
    assign level_o = pin_oe_n_i ? ~pull_low_i : pin_o_i;
endmodule

/* dual_timer_counter.sv */
// Dual 16-bit timer/counter with AXI4-Lite register access
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "dual_timer_counter_params.svh"

module dual_timer_counter (
    input  wire logic                             ref_clk_i,
    input  wire logic                             resetn_i,
    input  wire logic [11:0]                      s_axi_awaddr_i,
    input  wire logic                             s_axi_awvalid_i,
    output logic                                  s_axi_awready_o,
    input  wire logic [31:0]                      s_axi_wdata_i,
    input  wire logic [3:0]                       s_axi_wstrb_i,
    input  wire logic                             s_axi_wvalid_i,
    output logic                                  s_axi_wready_o,
    output dual_timer_counter_pkg::axi_resp_t     s_axi_bresp_o,
    output logic                                  s_axi_bvalid_o,
    input  wire logic                             s_axi_bready_i,
    input  wire logic [11:0]                      s_axi_araddr_i,
    input  wire logic                             s_axi_arvalid_i,
    output logic                                  s_axi_arready_o,
    output logic [31:0]                           s_axi_rdata_o,
    output dual_timer_counter_pkg::axi_resp_t     s_axi_rresp_o,
    output logic                                  s_axi_rvalid_o,
    input  wire logic                             s_axi_rready_i,
    input  wire logic                             t0_count_pin_i,
    output logic                                  t0_count_pin_o,
    output logic                                  t0_count_pin_oe_n_o,
    input  wire logic                             t1_count_pin_i,
    output logic                                  t1_count_pin_o,
    output logic                                  t1_count_pin_oe_n_o,
    input  wire logic                             ext_irq0_input_i,
    input  wire logic                             ext_irq1_input_i,
    input  wire logic                             t0_isr_enter_i,
    input  wire logic                             t1_isr_enter_i,
    output logic                                  t0_overflow_flag_o,
    output logic                                  t1_overflow_flag_o,
    output logic                                  t1_baud_tick_o
);
    import dual_timer_counter_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic is_mapped(input logic [11:0] a);
        logic [7:0] i;
        i = a[9:2];
        is_mapped = (a[11:10] == 2'h0) && (a[1:0] == 2'h0) &&
                    (i >= `IDX_CTRL) && (i <= `IDX_CLKSEL);
    endfunction

    // One count step: {overflow, high, low}
    function automatic logic [16:0] step(input tmr_mode_t m,
                                         input logic [7:0] hi,
                                         input logic [7:0] lo);
        logic [12:0] c13;
        logic [15:0] c16;
        logic [8:0]  c8;
        c13 = {hi, lo[4:0]} + 13'h0001;
        c16 = {hi, lo} + 16'h0001;
        c8  = {1'b0, lo} + 9'h001;
        unique case (m)
            MODE_13BIT:       step = {({hi, lo[4:0]} == 13'h1FFF),
                                      c13[12:5], lo[7:5], c13[4:0]};
            MODE_16BIT:       step = {({hi, lo} == 16'hFFFF), c16};
            MODE_8BIT_RELOAD: step = {c8[8], hi,
                                      c8[8] ? hi : c8[7:0]};
            MODE_SPLIT:       step = {c8[8], hi, c8[7:0]};
        endcase
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  mode_q;
    logic [7:0]  clksel_q;
    logic        tr0_q, tr1_q, tf0_q, tf1_q;
    logic [7:0]  t0_hi_q, t0_lo_q, t1_hi_q, t1_lo_q;
    logic [7:0]  t0_hi_d, t0_lo_d, t1_hi_d, t1_lo_d;
    logic [3:0]  presc_q;
    logic        pin0_prev_q, pin1_prev_q;
    logic        tog0_q, tog1_q, oe0_n_q, oe1_n_q, baud_q;

    logic        aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
    logic [11:0] aw_addr_q;
    logic [7:0]  w_data_q;
    logic        w_strb0_q;
    axi_resp_t   bresp_q, rresp_q;
    logic        arready_q, rvalid_q;
    logic [31:0] rdata_q;

    logic        wr_fire, wr_en;
    logic [7:0]  wr_idx;
    tmr_mode_t   m0, m1;
    logic        gate0, gate1, ct0, ct1, t0_split;
    logic        presc_tick, tick0, tick1, fall0, fall1;
    logic        run0, run1, inc0, inc1;
    logic        t0_ovf, t1_ovf, th0_ovf, set_tf0, set_tf1;
    logic [16:0] s0, s1;

    assign m0    = tmr_mode_t'(mode_q[`MODE_M_HI_BIT:`MODE_M_LO_BIT]);
    assign m1    = tmr_mode_t'(mode_q[`MODE_T1_OFS+1:`MODE_T1_OFS]);
    assign gate0 = mode_q[`MODE_GATE_BIT];
    assign gate1 = mode_q[`MODE_GATE_BIT+`MODE_T1_OFS];
    assign ct0   = mode_q[`MODE_CT_BIT];
    assign ct1   = mode_q[`MODE_CT_BIT+`MODE_T1_OFS];
    assign t0_split = (m0 == MODE_SPLIT);

    assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
    assign wr_en   = wr_fire && w_strb0_q && is_mapped(aw_addr_q);
    assign wr_idx  = aw_addr_q[9:2];

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    // Address and data are taken in either order; response after both
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RESP_OKAY;
            aw_addr_q <= 12'h000;
            w_data_q  <= 8'h00;
            w_strb0_q <= 1'b0;
        end else begin
            if (s_axi_awvalid_i && awready_q) begin
                aw_full_q <= 1'b1;
                awready_q <= 1'b0;
                aw_addr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && wready_q) begin
                w_full_q  <= 1'b1;
                wready_q  <= 1'b0;
                w_data_q  <= s_axi_wdata_i[7:0];
                w_strb0_q <= s_axi_wstrb_i[0];
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= is_mapped(aw_addr_q) ? `RESP_OKAY
                                                  : `RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready_i) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `RESP_OKAY;
        end else if (s_axi_arvalid_i && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= is_mapped(s_axi_araddr_i) ? `RESP_OKAY
                                                   : `RESP_SLVERR;
            rdata_q   <= 32'h0000_0000;
            if (is_mapped(s_axi_araddr_i)) begin
                unique case (s_axi_araddr_i[9:2])
                    `IDX_CTRL:    rdata_q[7:0] <= {tf1_q, tr1_q,
                                                   tf0_q, tr0_q, 4'h0};
                    `IDX_MODE:    rdata_q[7:0] <= mode_q;
                    `IDX_T0_LOW:  rdata_q[7:0] <= t0_lo_q;
                    `IDX_T1_LOW:  rdata_q[7:0] <= t1_lo_q;
                    `IDX_T0_HIGH: rdata_q[7:0] <= t0_hi_q;
                    `IDX_T1_HIGH: rdata_q[7:0] <= t1_hi_q;
                    default:      rdata_q[7:0] <= clksel_q;
                endcase
            end
        end else if (rvalid_q && s_axi_rready_i) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_q   <= `REG_RESET;
            clksel_q <= `REG_RESET;
            oe0_n_q  <= 1'b1;
            oe1_n_q  <= 1'b1;
            tr0_q    <= 1'b0;
            tr1_q    <= 1'b0;
        end else if (wr_en) begin
            if (wr_idx == `IDX_MODE) begin
                mode_q <= w_data_q;
            end
            if (wr_idx == `IDX_CLKSEL) begin
                clksel_q <= w_data_q;
                oe0_n_q  <= !w_data_q[`CLK_T0_TOE_BIT];
                oe1_n_q  <= !w_data_q[`CLK_T1_TOE_BIT];
            end
            if (wr_idx == `IDX_CTRL) begin
                tr0_q <= w_data_q[`CTRL_TR0_BIT];
                tr1_q <= w_data_q[`CTRL_TR1_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Clock sources
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            presc_q     <= 4'h0;
            pin0_prev_q <= 1'b0;
            pin1_prev_q <= 1'b0;
        end else begin
            presc_q     <= presc_tick ? 4'h0 : presc_q + 4'h1;
            pin0_prev_q <= t0_count_pin_i;
            pin1_prev_q <= t1_count_pin_i;
        end
    end

    assign presc_tick = (presc_q == `PRESC_LAST);
    assign tick0 = clksel_q[`CLK_T0_DIV_BIT] || presc_tick;
    assign tick1 = clksel_q[`CLK_T1_DIV_BIT] || presc_tick;
    // Pins are synchronous here; a sampled high-then-low is one edge
    assign fall0 = pin0_prev_q && !t0_count_pin_i;
    assign fall1 = pin1_prev_q && !t1_count_pin_i;

    // ------------------------------------------------------------
    // Count enables
    // ------------------------------------------------------------
    assign run0 = tr0_q && (!gate0 || ext_irq0_input_i);
    assign inc0 = run0 && (ct0 ? fall0 : tick0);
    // In split mode timer 1 loses its run bit but keeps its gate
    assign run1 = (t0_split || tr1_q) && (!gate1 || ext_irq1_input_i) &&
                  (m1 != MODE_SPLIT);
    assign inc1 = run1 && (ct1 ? fall1 : tick1);

    // ------------------------------------------------------------
    // Count bytes
    // ------------------------------------------------------------
    // A bus write beats a count step in the same cycle
    always_comb begin
        s0      = step(m0, t0_hi_q, t0_lo_q);
        s1      = step(m1, t1_hi_q, t1_lo_q);
        t0_hi_d = t0_hi_q;
        t0_lo_d = t0_lo_q;
        t1_hi_d = t1_hi_q;
        t1_lo_d = t1_lo_q;
        t0_ovf  = 1'b0;
        t1_ovf  = 1'b0;
        th0_ovf = 1'b0;
        if (inc0) begin
            {t0_ovf, t0_hi_d, t0_lo_d} = s0;
        end
        if (t0_split && tr1_q && tick0) begin
            {th0_ovf, t0_hi_d} = {1'b0, t0_hi_q} + 9'h001;
        end
        if (inc1) begin
            {t1_ovf, t1_hi_d, t1_lo_d} = s1;
        end
        if (wr_en && wr_idx == `IDX_T0_LOW) begin
            t0_lo_d = w_data_q;
        end
        if (wr_en && wr_idx == `IDX_T0_HIGH) begin
            t0_hi_d = w_data_q;
        end
        if (wr_en && wr_idx == `IDX_T1_LOW) begin
            t1_lo_d = w_data_q;
        end
        if (wr_en && wr_idx == `IDX_T1_HIGH) begin
            t1_hi_d = w_data_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            t0_hi_q <= 8'h00;
            t0_lo_q <= 8'h00;
            t1_hi_q <= 8'h00;
            t1_lo_q <= 8'h00;
        end else begin
            t0_hi_q <= t0_hi_d;
            t0_lo_q <= t0_lo_d;
            t1_hi_q <= t1_hi_d;
            t1_lo_q <= t1_lo_d;
        end
    end

    // ------------------------------------------------------------
    // Overflow flags
    // ------------------------------------------------------------
    // Hardware set wins over software clear and service clear
    assign set_tf0 = t0_ovf;
    assign set_tf1 = (t1_ovf && !t0_split) || th0_ovf;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tf0_q <= 1'b0;
            tf1_q <= 1'b0;
        end else begin
            if (set_tf0) begin
                tf0_q <= 1'b1;
            end else if (wr_en && wr_idx == `IDX_CTRL) begin
                tf0_q <= w_data_q[`CTRL_TF0_BIT];
            end else if (t0_isr_enter_i) begin
                tf0_q <= 1'b0;
            end
            if (set_tf1) begin
                tf1_q <= 1'b1;
            end else if (wr_en && wr_idx == `IDX_CTRL) begin
                tf1_q <= w_data_q[`CTRL_TF1_BIT];
            end else if (t1_isr_enter_i) begin
                tf1_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Toggle outputs and baud tick
    // ------------------------------------------------------------
    // Held at one while disabled, so it starts high when enabled
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tog0_q <= 1'b1;
            tog1_q <= 1'b1;
            baud_q <= 1'b0;
        end else begin
            if (oe0_n_q) begin
                tog0_q <= 1'b1;
            end else if (t0_ovf) begin
                tog0_q <= !tog0_q;
            end
            if (oe1_n_q) begin
                tog1_q <= 1'b1;
            end else if (t1_ovf) begin
                tog1_q <= !tog1_q;
            end
            baud_q <= t1_ovf;
        end
    end

    assign s_axi_awready_o     = awready_q;
    assign s_axi_wready_o      = wready_q;
    assign s_axi_bvalid_o      = bvalid_q;
    assign s_axi_bresp_o       = bresp_q;
    assign s_axi_arready_o     = arready_q;
    assign s_axi_rvalid_o      = rvalid_q;
    assign s_axi_rdata_o       = rdata_q;
    assign s_axi_rresp_o       = rresp_q;
    assign t0_count_pin_o      = tog0_q;
    assign t1_count_pin_o      = tog1_q;
    assign t0_count_pin_oe_n_o = oe0_n_q;
    assign t1_count_pin_oe_n_o = oe1_n_q;
    assign t0_overflow_flag_o  = tf0_q;
    assign t1_overflow_flag_o  = tf1_q;
    assign t1_baud_tick_o      = baud_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic wr_t0, wr_t1;
    assign wr_t0 = wr_en && (wr_idx == `IDX_T0_LOW || wr_idx == `IDX_T0_HIGH);
    assign wr_t1 = wr_en && (wr_idx == `IDX_T1_LOW || wr_idx == `IDX_T1_HIGH);

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    property p_div12;
        presc_tick |=> !presc_tick [*8] ##1 !presc_tick ##1 !presc_tick
                       ##1 !presc_tick ##1 presc_tick;
    endproperty
    a_div12: assert property (p_div12) else $error("prescaler not 12");

    property p_edge_count;
        (m0 == MODE_16BIT && ct0 && run0 && fall0 && !wr_t0) |=>
            ({t0_hi_q, t0_lo_q} == $past({t0_hi_q, t0_lo_q}) + 16'h0001);
    endproperty
    a_edge_count: assert property (p_edge_count)
        else $error("edge not counted");

    property p_no_edge;
        (m0 == MODE_16BIT && ct0 && !fall0 && !wr_t0 && !t0_split) |=>
            $stable({t0_hi_q, t0_lo_q});
    endproperty
    a_no_edge: assert property (p_no_edge)
        else $error("counted without edge");

    property p_toggle;
        (!oe0_n_q && t0_ovf) |=> (t0_count_pin_o != $past(t0_count_pin_o));
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle");

    property p_tog_idle;
        oe0_n_q |=> t0_count_pin_o;
    endproperty
    a_tog_idle: assert property (p_tog_idle) else $error("toggle not 1");

    property p_m0_upper;
        (m0 == MODE_13BIT && !wr_t0) |=> $stable(t0_lo_q[7:5]);
    endproperty
    a_m0_upper: assert property (p_m0_upper)
        else $error("upper low bits moved");

    property p_halt;
        (!run0 && !wr_t0 && !t0_split) |=> $stable({t0_hi_q, t0_lo_q});
    endproperty
    a_halt: assert property (p_halt) else $error("counted while off");

    property p_ovf_flag;
        t0_ovf |=> tf0_q;
    endproperty
    a_ovf_flag: assert property (p_ovf_flag)
        else $error("flag not set");

    property p_reload;
        (m0 == MODE_8BIT_RELOAD && t0_ovf && !wr_t0) |=>
            (t0_lo_q == t0_hi_q) && $stable(t0_hi_q);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload");

    property p_t1_freeze;
        (m1 == MODE_SPLIT && !wr_t1) |=> $stable({t1_hi_q, t1_lo_q});
    endproperty
    a_t1_freeze: assert property (p_t1_freeze)
        else $error("timer 1 moved");

    property p_split_flag;
        (t0_split && t1_ovf && !th0_ovf && !tf1_q && !wr_en) |=> !tf1_q;
    endproperty
    a_split_flag: assert property (p_split_flag)
        else $error("timer 1 set flag");

    property p_isr_clear;
        (t0_isr_enter_i && !set_tf0 && !wr_en) |=> !tf0_q;
    endproperty
    a_isr_clear: assert property (p_isr_clear)
        else $error("flag not cleared");

    c_t0_ovf: cover property (t0_ovf ##1 tf0_q);
    c_split_hi: cover property (t0_split && th0_ovf);
    c_toggle: cover property (!oe0_n_q && t0_ovf);
    c_baud: cover property (t1_baud_tick_o);
endmodule

/* dual_timer_counter_params.svh */
// Offsets, field positions, reset values and counts of the dual timer
`ifndef DUAL_TIMER_COUNTER_PARAMS_SVH
`define DUAL_TIMER_COUNTER_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_CTRL        8'h88
`define IDX_MODE        8'h89
`define IDX_T0_LOW      8'h8A
`define IDX_T1_LOW      8'h8B
`define IDX_T0_HIGH     8'h8C
`define IDX_T1_HIGH     8'h8D
`define IDX_CLKSEL      8'h8E

// Control register fields
`define CTRL_TF1_BIT    7
`define CTRL_TR1_BIT    6
`define CTRL_TF0_BIT    5
`define CTRL_TR0_BIT    4

// Mode register fields, timer 1 at +4
`define MODE_GATE_BIT   3
`define MODE_CT_BIT     2
`define MODE_M_HI_BIT   1
`define MODE_M_LO_BIT   0
`define MODE_T1_OFS     4

// Clock-select register fields
`define CLK_T0_DIV_BIT  3
`define CLK_T1_DIV_BIT  4
`define CLK_T0_TOE_BIT  5
`define CLK_T1_TOE_BIT  6

`define REG_RESET       8'h00
`define PRESC_LAST      4'hB
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* dual_timer_counter_pkg.sv */
// Types shared by the dual timer/counter
package dual_timer_counter_pkg;
    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_8BIT_RELOAD,
        MODE_SPLIT
    } tmr_mode_t;
    typedef logic [1:0] axi_resp_t;
endpackage

/* dual_timer_counter_tb.sv */
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ns
`include "dual_timer_counter_params.svh"

module dual_timer_counter_tb;
    import dual_timer_counter_pkg::*;
    logic        clk, rst_n, awv, wv, bry, arv, rry, irq0, isr0, drv0;
    logic        awr, wrd, bv, arr, rv, p0o, p0oe_n, pin0, f0;
    logic        p1o, p1oe_n, bt, f1;
    logic [11:0] awa, ara;
    logic [31:0] wd, rd, rdat, x;
    axi_resp_t   rs, rrs, bs, brs;
    int          error_cnt, checks_done, cyc, nbaud;

    dual_timer_counter u_dual_timer_counter (
        .ref_clk_i(clk), .resetn_i(rst_n),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wrd), .s_axi_bresp_o(brs), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bry), .s_axi_araddr_i(ara),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdat), .s_axi_rresp_o(rrs),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
        .t0_count_pin_i(pin0), .t0_count_pin_o(p0o),
        .t0_count_pin_oe_n_o(p0oe_n), .t1_count_pin_i(1'b1),
        .t1_count_pin_o(p1o), .t1_count_pin_oe_n_o(p1oe_n),
        .ext_irq0_input_i(irq0), .ext_irq1_input_i(1'b1),
        .t0_isr_enter_i(isr0), .t1_isr_enter_i(1'b0),
        .t0_overflow_flag_o(f0), .t1_overflow_flag_o(f1),
        .t1_baud_tick_o(bt));

    count_pin_model u_count_pin_model (
        .pin_o_i(p0o), .pin_oe_n_i(p0oe_n), .pull_low_i(drv0),
        .level_o(pin0));

    // -----------------------------------------------------------------
    // Bus and compare tasks
    // -----------------------------------------------------------------
    function automatic logic [11:0] ba(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge clk);
        awa <= ba(i);
        wd  <= {24'h0, d};
        awv <= 1'b1;
        wv  <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (bv !== 1'b1);
        bs = brs;
        bry <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] i);
        @(posedge clk);
        ara <= ba(i);
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rd = rdat;
        rs = rrs;
        rry <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] i, input logic [7:0] e);
        rdr(i);
        chk(rd, {24'h0, e});
    endtask

    task automatic run_t0(input logic [7:0] m, input logic [7:0] lo,
                          input logic [7:0] hi, input int n);
        wr(`IDX_MODE, m);
        wr(`IDX_T0_LOW, lo);
        wr(`IDX_T0_HIGH, hi);
        wr(`IDX_CTRL, 8'h10);
        repeat (n) @(posedge clk);
    endtask

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_reset;
        rdchk(`IDX_MODE, 8'h00);
        rdchk(`IDX_CTRL, 8'h00);
        rdr(8'h90);
        chk(32'(rs), 32'(`RESP_SLVERR));
        wr(8'h90, 8'h00);
        chk(32'(bs), 32'(`RESP_SLVERR));
        wr(`IDX_MODE, 8'hA5);
        rdchk(`IDX_MODE, 8'hA5);
    endtask

    task automatic t_div12;
        wr(`IDX_CLKSEL, 8'h00);
        run_t0(8'h01, 8'h00, 8'h00, 120);
        wr(`IDX_CTRL, 8'h00);
        rdr(`IDX_T0_LOW);
        // Bus latency blurs the window by one prescaler tick
        chk(32'(rd >= 10 && rd <= 11), 32'h1);
    endtask

    task automatic t_counter;
        run_t0(8'h05, 8'h00, 8'h00, 2);
        repeat (3) begin
            drv0 <= 1'b1;
            repeat (2) @(posedge clk);
            drv0 <= 1'b0;
            repeat (2) @(posedge clk);
        end
        wr(`IDX_CTRL, 8'h00);
        rdchk(`IDX_T0_LOW, 8'h03);
    endtask

    task automatic t_gate;
        wr(`IDX_CLKSEL, 8'h08);
        run_t0(8'h09, 8'h00, 8'h00, 20);
        wr(`IDX_CTRL, 8'h00);
        rdchk(`IDX_T0_LOW, 8'h00);
    endtask

    task automatic t_mode0;
        run_t0(8'h00, 8'hFE, 8'hFF, 6);
        chk(32'(f0), 32'h1);
        wr(`IDX_CTRL, 8'h00);
        rdchk(`IDX_T0_HIGH, 8'h00);
        rdr(`IDX_T0_LOW);
        chk({29'h0, rd[7:5]}, 32'h7);
    endtask

    task automatic t_mode1;
        run_t0(8'h01, 8'hFE, 8'hFF, 6);
        chk(32'(f0), 32'h1);
        isr0 <= 1'b1;
        @(posedge clk);
        isr0 <= 1'b0;
        @(posedge clk);
        chk(32'(f0), 32'h0);
        wr(`IDX_CTRL, 8'h00);
        rdr(`IDX_T0_LOW);
        x = rd;
        repeat (10) @(posedge clk);
        rdchk(`IDX_T0_LOW, x[7:0]);
        rdchk(`IDX_T0_HIGH, 8'h00);
    endtask

    task automatic t_reload;
        run_t0(8'h02, 8'hFE, 8'h80, 4);
        chk(32'(f0), 32'h1);
        wr(`IDX_CTRL, 8'h00);
        rdchk(`IDX_T0_HIGH, 8'h80);
        rdr(`IDX_T0_LOW);
        chk({28'h0, rd[7:4]}, 32'h8);
    endtask

    task automatic t_toggle;
        wr(`IDX_CLKSEL, 8'h28);
        @(posedge clk);
        chk({30'h0, p0oe_n, pin0}, 32'h1);
        run_t0(8'h01, 8'hFE, 8'hFF, 6);
        chk(32'(pin0), 32'h0);
        wr(`IDX_CTRL, 8'h00);
        wr(`IDX_CLKSEL, 8'h18);
    endtask

    task automatic t_t1_hold;
        wr(`IDX_MODE, 8'h30);
        wr(`IDX_T1_LOW, 8'h55);
        wr(`IDX_CTRL, 8'h40);
        repeat (30) @(posedge clk);
        rdchk(`IDX_T1_LOW, 8'h55);
    endtask

    task automatic t_split;
        wr(`IDX_CTRL, 8'h00);
        wr(`IDX_CLKSEL, 8'h58);
        wr(`IDX_T1_HIGH, 8'hFF);
        wr(`IDX_T1_LOW, 8'h1F);
        wr(`IDX_T0_HIGH, 8'hFE);
        wr(`IDX_T0_LOW, 8'h11);
        // Timer 1 leaves its own mode 3 and wraps at once
        wr(`IDX_MODE, 8'h03);
        repeat (4) @(posedge clk);
        chk({30'h0, p1oe_n, p1o}, 32'h0);
        chk(32'(nbaud), 32'h1);
        rdchk(`IDX_CTRL, 8'h00);
        rdchk(`IDX_T1_HIGH, 8'h00);
        wr(`IDX_CTRL, 8'h40);
        repeat (4) @(posedge clk);
        chk(32'(f1), 32'h1);
        rdchk(`IDX_CTRL, 8'hC0);
        rdchk(`IDX_T0_LOW, 8'h11);
    endtask

    task automatic end_sim;
        $display("errors=%0d checks=%0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // -----------------------------------------------------------------
    // Clock, timeout, sequence
    // -----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (bt) nbaud <= nbaud + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end

    initial begin
        {rst_n, awv, wv, bry, arv, rry, irq0, isr0, drv0} = '0;
        {awa, ara, wd, error_cnt, checks_done, cyc, nbaud} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_div12();
        t_counter();
        t_gate();
        irq0 <= 1'b1;
        t_mode0();
        t_mode1();
        t_reload();
        t_toggle();
        t_t1_hold();
        t_split();
        end_sim();
    end
endmodule
